//--- hdl/clkgen_pkg.sv
// Constants and carrier types for the loop clock generator
package clkgen_pkg;
    // -----------------------------------------------------------------
    // Timebase
    // -----------------------------------------------------------------
    localparam int CLK_KHZ      = 40000;
    localparam int IRC_KHZ      = 1000;
    localparam int IRC_CYCLES   = CLK_KHZ / IRC_KHZ;
    // -----------------------------------------------------------------
    // Field widths and reset values
    // -----------------------------------------------------------------
    localparam int REFERENCE_DIVIDER_W     = 4;
    localparam int SYN_W        = 6;
    localparam int POST_W       = 5;
    localparam int FILT_W       = 5;
    localparam logic [SYN_W-1:0]  RST_SYN    = 6'h1f;
    localparam logic [POST_W-1:0] RST_POST   = 5'h03;
    localparam logic [POST_W-1:0] UNLOCK_DIV = 5'h03;
    // -----------------------------------------------------------------
    // Loop model
    // -----------------------------------------------------------------
    localparam int NCO_W        = 16;
    localparam logic [NCO_W-1:0] INCR_RST = 16'h4000;
    localparam logic [NCO_W-1:0] INCR_MIN = 16'h0001;
    localparam int GAIN_SH      = 5;
    localparam logic [8:0] LOCK_TOL   = 9'h002;
    localparam logic [8:0] UNLOCK_TOL = 9'h004;
    localparam logic [2:0] LOCK_REFS  = 3'h4;
    localparam logic [2:0] QUAL_EDGES = 3'h4;
    localparam logic [4:0] DET_NARROW = 5'h02;
    localparam logic [4:0] DET_ANY    = 5'h04;

    typedef struct packed {
        logic                crystal_enable;
        logic [REFERENCE_DIVIDER_W-1:0] reference_divider;
        logic [SYN_W-1:0]    synth_multiplier;
        logic [POST_W-1:0]   output_divider;
        logic                bus_source_select;
        logic [FILT_W-1:0]   spike_filter_ratio;
        logic                filter_wide_window;
        logic                lock_irq_enable;
        logic                crystal_irq_enable;
    } cfg_t;

    typedef struct packed {
        logic lock;
        logic crystal_qualified;
        logic lock_change_flag;
        logic crystal_change_flag;
    } stat_t;
endpackage : clkgen_pkg

//--- hdl/loop_clock_gen.sv
// Loop clock generator with adaptive crystal spike filter
// Notes on behaviour
// - Crystal disabled: internal 1 MHz tick is the loop reference
// - Crystal enabled: reference is crystal divided by divider field plus one
// - VCO runs at twice reference times multiplier field plus one
// - Locked: output clock is VCO divided by output divider plus one
// - Unlocked for any reason: output clock is VCO divided by four
// - Bus clock is half the output clock when loop source selected
// - Feedback toggles every multiplier plus one VCO ticks; loop corrects VCO rate
// - Lock decided by comparing feedback and reference frequencies
// - Lock bit sets inside lock tolerance, clears outside unlock tolerance
// - Lock change flag raises interrupt when lock interrupt enabled
// - Enabled filter removes spikes from crystal clock
// - Filter samples crystal with VCO; software writes ratio over two
// - Edge window is three VCO cycles wide, else one
// - Ratio 0 off, 1 filter only, 2-3 detect narrow, 4+ both
// - Severe noise clears qualified and lock, sets both change flags
// - Reset: internal reference, 64 MHz VCO setting, output divider 3
// - Source select low: crystal clock drives the bus clock
module loop_clock_gen
    import clkgen_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    input  wire clkgen_pkg::cfg_t cfg_i,
    input  wire logic             lock_flag_clear_i,
    input  wire logic             crystal_flag_clear_i,
    input  wire logic             crystal_input_pin_i,
    output logic                  vco_clock_o,
    output logic                  feedback_clock_o,
    output logic                  loop_reference_clock_o,
    output logic                  loop_output_clock_o,
    output logic                  bus_clock_o,
    output logic                  crystal_clock_o,
    output clkgen_pkg::stat_t     status_o,
    output logic                  lock_irq_o,
    output logic                  crystal_irq_o
);
    // -----------------------------------------------------------------
    // Crystal input synchroniser
    // -----------------------------------------------------------------
    logic xtal_m_q;
    logic xtal_s_q;
    always_ff @(posedge mclk_i)
    begin
        xtal_m_q <= crystal_input_pin_i;
        xtal_s_q <= xtal_m_q;
    end

    // -----------------------------------------------------------------
    // VCO as a numerically controlled oscillator
    // -----------------------------------------------------------------
    logic [NCO_W-1:0] acc_q;
    logic [NCO_W-1:0] incr_q;
    logic             vco_q;
    logic [NCO_W:0]   acc_sum;
    assign acc_sum = {1'b0, acc_q} + {1'b0, incr_q};
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            acc_q <= '0;
            vco_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_sum[NCO_W-1:0];
            vco_q <= acc_sum[NCO_W];
        end
    end

    // -----------------------------------------------------------------
    // Adaptive spike filter, sampled on VCO ticks
    // -----------------------------------------------------------------
    logic [6:0] fcnt_q;
    logic       filt_q;
    logic [6:0] fnxt;
    logic [6:0] ratio;
    logic [6:0] wdt;
    logic [6:0] lo;
    logic       filt_on;
    logic       det_on;
    logic       miss;
    logic       noise;
    assign ratio   = {2'b00, cfg_i.spike_filter_ratio};
    assign wdt     = {6'h00, cfg_i.filter_wide_window};
    assign fnxt    = fcnt_q + 7'h01;
    assign lo      = (ratio > wdt) ? ratio - wdt : 7'h01;
    assign filt_on = cfg_i.spike_filter_ratio != '0;
    assign det_on  = (cfg_i.spike_filter_ratio >= DET_ANY) ||
                     ((cfg_i.spike_filter_ratio >= DET_NARROW) &&
                      !cfg_i.filter_wide_window);
    assign miss    = (fnxt > ratio + wdt) && (xtal_s_q == filt_q);
    assign noise   = vco_q && filt_on && det_on && cfg_i.crystal_enable && miss;
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !filt_on)
        begin
            fcnt_q <= '0;
            filt_q <= xtal_s_q;
        end
        else if (vco_q)
        begin
            if ((xtal_s_q != filt_q && fnxt >= lo) || miss)
            begin
                filt_q <= !filt_q;
                fcnt_q <= '0;
            end
            else
            begin
                fcnt_q <= fnxt;
            end
        end
    end

    logic xtal_clk;
    logic xtal_prev_q;
    logic xtal_rise;
    assign xtal_clk  = filt_on ? filt_q : xtal_s_q;
    assign xtal_rise = xtal_clk && !xtal_prev_q;
    always_ff @(posedge mclk_i)
    begin
        xtal_prev_q <= reset_i ? 1'b0 : xtal_clk;
    end

    // -----------------------------------------------------------------
    // Crystal qualification
    // -----------------------------------------------------------------
    logic [2:0] qcnt_q;
    logic       qual_q;
    logic       qual_d;
    always_comb
    begin
        qual_d = qual_q;
        if (!cfg_i.crystal_enable || noise)
            qual_d = 1'b0;
        else if (xtal_rise && qcnt_q == QUAL_EDGES - 3'h1)
            qual_d = 1'b1;
    end
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !cfg_i.crystal_enable || noise)
            qcnt_q <= '0;
        else if (xtal_rise && qcnt_q != QUAL_EDGES - 3'h1)
            qcnt_q <= qcnt_q + 3'h1;
    end
    always_ff @(posedge mclk_i)
    begin
        qual_q <= reset_i ? 1'b0 : qual_d;
    end

    // -----------------------------------------------------------------
    // Loop reference selection and division
    // -----------------------------------------------------------------
    logic [5:0]          irc_q;
    logic                irc_tick;
    logic [REFERENCE_DIVIDER_W-1:0] rdiv_q;
    logic                ref_ev;
    assign irc_tick = irc_q == 6'(IRC_CYCLES - 1);
    assign ref_ev   = cfg_i.crystal_enable ?
                      (xtal_rise && rdiv_q == cfg_i.reference_divider) :
                      irc_tick;
    always_ff @(posedge mclk_i)
    begin
        irc_q <= (reset_i || irc_tick) ? '0 : irc_q + 6'h01;
    end
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !cfg_i.crystal_enable)
            rdiv_q <= '0;
        else if (xtal_rise)
            rdiv_q <= (rdiv_q == cfg_i.reference_divider) ? '0 : rdiv_q + 4'h1;
    end

    // -----------------------------------------------------------------
    // Feedback divider
    // -----------------------------------------------------------------
    logic [SYN_W-1:0] fb_cnt_q;
    logic             fb_q;
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            fb_cnt_q <= '0;
            fb_q     <= 1'b0;
        end
        else if (vco_q)
        begin
            if (fb_cnt_q >= cfg_i.synth_multiplier)
            begin
                fb_cnt_q <= '0;
                fb_q     <= !fb_q;
            end
            else
                fb_cnt_q <= fb_cnt_q + 6'h01;
        end
    end

    // -----------------------------------------------------------------
    // Frequency comparison and VCO correction
    // -----------------------------------------------------------------
    logic [7:0]        vcnt_q;
    logic [8:0]        vcnt_now;
    logic signed [8:0] err;
    logic [8:0]        mag;
    logic signed [NCO_W+1:0] incr_n;
    assign vcnt_now = {1'b0, vcnt_q} + {8'h00, vco_q};
    assign err = signed'({2'b00, cfg_i.synth_multiplier, 1'b0} + 9'h002) -
                 signed'(vcnt_now);
    assign mag = err[8] ? 9'(-err) : err;
    assign incr_n = signed'({2'b00, incr_q}) + ((NCO_W+2)'(err) <<< GAIN_SH);
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || ref_ev)
            vcnt_q <= '0;
        else if (vco_q && vcnt_q != 8'hff)
            vcnt_q <= vcnt_q + 8'h01;
    end
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            incr_q <= INCR_RST;
        else if (ref_ev)
        begin
            if (incr_n < signed'({2'b00, INCR_MIN}))
                incr_q <= INCR_MIN;
            else if (incr_n[NCO_W+1:NCO_W] != 2'b00)
                incr_q <= '1;
            else
                incr_q <= incr_n[NCO_W-1:0];
        end
    end

    // -----------------------------------------------------------------
    // Lock detector
    // -----------------------------------------------------------------
    logic [2:0] good_q;
    logic       lock_q;
    logic       lock_d;
    always_comb
    begin
        lock_d = lock_q;
        if (noise || (ref_ev && mag > UNLOCK_TOL))
            lock_d = 1'b0;
        else if (ref_ev && mag <= LOCK_TOL && good_q == LOCK_REFS - 3'h1)
            lock_d = 1'b1;
    end
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || noise || (ref_ev && mag > LOCK_TOL))
            good_q <= '0;
        else if (ref_ev && good_q != LOCK_REFS - 3'h1)
            good_q <= good_q + 3'h1;
    end
    always_ff @(posedge mclk_i)
    begin
        lock_q <= reset_i ? 1'b0 : lock_d;
    end

    // -----------------------------------------------------------------
    // Change flags, set wins over clear
    // -----------------------------------------------------------------
    logic lflag_q;
    logic cflag_q;
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            lflag_q <= 1'b0;
        else if (lock_d != lock_q || noise)
            lflag_q <= 1'b1;
        else if (lock_flag_clear_i)
            lflag_q <= 1'b0;
    end
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            cflag_q <= 1'b0;
        else if (qual_d != qual_q || noise)
            cflag_q <= 1'b1;
        else if (crystal_flag_clear_i)
            cflag_q <= 1'b0;
    end

    // -----------------------------------------------------------------
    // Output divider and bus clock
    // -----------------------------------------------------------------
    logic [POST_W-1:0] pcnt_q;
    logic [POST_W-1:0] div_q;
    logic              pll_tick;
    logic              bus_ph_q;
    logic              pll_q;
    logic              bus_q;
    assign pll_tick = vco_q && pcnt_q >= div_q;
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            pcnt_q <= '0;
            div_q  <= UNLOCK_DIV;
        end
        else if (pll_tick)
        begin
            pcnt_q <= '0;
            div_q  <= lock_q ? cfg_i.output_divider : UNLOCK_DIV;
        end
        else if (vco_q)
            pcnt_q <= pcnt_q + 5'h01;
    end
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            bus_ph_q <= 1'b0;
            pll_q    <= 1'b0;
            bus_q    <= 1'b0;
        end
        else
        begin
            bus_ph_q <= bus_ph_q ^ pll_tick;
            pll_q    <= pll_tick;
            bus_q    <= cfg_i.bus_source_select ? (pll_tick && bus_ph_q) :
                        xtal_rise;
        end
    end

    assign vco_clock_o            = vco_q;
    assign feedback_clock_o       = fb_q;
    assign loop_reference_clock_o = ref_ev;
    assign loop_output_clock_o    = pll_q;
    assign bus_clock_o            = bus_q;
    assign crystal_clock_o        = xtal_clk;
    assign status_o               = '{lock: lock_q, crystal_qualified: qual_q,
                                      lock_change_flag: lflag_q,
                                      crystal_change_flag: cflag_q};
    assign lock_irq_o             = lflag_q && cfg_i.lock_irq_enable;
    assign crystal_irq_o          = cflag_q && cfg_i.crystal_irq_enable;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_ref_internal: assert property (ref_ev && !cfg_i.crystal_enable |-> irc_tick)
        else $error("reference not internal tick");
    a_ref_divided: assert property (ref_ev && cfg_i.crystal_enable |->
        xtal_rise && rdiv_q == cfg_i.reference_divider)
        else $error("reference divide wrong");
    a_div_select: assert property (pll_tick |=>
        div_q == ($past(lock_q) ? $past(cfg_i.output_divider) : UNLOCK_DIV))
        else $error("output divisor wrong");
    a_div_stable: assert property (!pll_tick |=> $stable(div_q))
        else $error("divisor changed mid period");
    a_bus_half: assert property (cfg_i.bus_source_select && pll_tick && bus_ph_q
        |=> bus_clock_o ##1 !bus_clock_o)
        else $error("bus tick missing");
    a_bus_crystal: assert property (!cfg_i.bus_source_select |=>
        bus_clock_o == $past(xtal_rise))
        else $error("bus not on crystal");
    a_fb_toggle: assert property (vco_q && fb_cnt_q >= cfg_i.synth_multiplier
        |=> fb_q != $past(fb_q))
        else $error("feedback did not toggle");
    a_unlock_tol: assert property (ref_ev && mag > UNLOCK_TOL |=> !lock_q)
        else $error("lock held out of tolerance");
    a_lock_flag: assert property (lock_q != $past(lock_q) |-> lflag_q)
        else $error("lock change not flagged");
    a_noise_status: assert property (noise |=>
        !lock_q && !qual_q && lflag_q && cflag_q)
        else $error("noise status wrong");
    a_spike_hold: assert property (vco_q && filt_on && fnxt < lo && !miss
        |=> $stable(filt_q))
        else $error("spike passed filter");
    a_filter_off: assert property (!filt_on |-> crystal_clock_o == xtal_s_q)
        else $error("filter active when off");
endmodule : loop_clock_gen

//--- bench/crystal_model.sv
// Behavioural crystal input: steady square wave, commanded spike and stall
module crystal_model (
    input  wire logic       mclk_i,
    input  wire logic       run_i,
    input  wire logic       spike_i,
    input  wire logic [7:0] half_i,
    output logic            pin_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] cnt_q   = 8'h00;
    logic       level_q = 1'b0;
    logic       armed_q = 1'b0;
    logic [1:0] burst_q = 2'h0;

    // ------------------------------------------------------------
    // Square wave, held level while stalled
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (run_i)
        begin
            if (cnt_q + 8'h01 >= half_i)
            begin
                cnt_q   <= 8'h00;
                level_q <= ~level_q;
            end
            else
                cnt_q <= cnt_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Two-cycle spike in the middle of the next low phase
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (spike_i)
            armed_q <= 1'b1;
        else if (armed_q && !level_q && cnt_q == (half_i >> 1))
        begin
            armed_q <= 1'b0;
            burst_q <= 2'h2;
        end
        else if (burst_q != 2'h0)
            burst_q <= burst_q - 2'h1;
    end

    assign pin_o = level_q | (burst_q != 2'h0);
endmodule : crystal_model

//--- bench/tb_pll_clock_generator_osc_filter.sv
// Self-checking bench for the loop clock generator
module tb_pll_clock_generator_osc_filter;
    import clkgen_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic       mclk_i, reset_i, lock_clr, xtal_clr, run, spike;
    logic [7:0] half;
    cfg_t       cfg;
    stat_t      st;
    logic       pin, vco, fb, refc, outc, busc, xclk, lirq, xirq;
    logic       fb_q, pin_q, filt_q;
    int         miscompares, tests_run;

    loop_clock_gen uut (
        .mclk_i(mclk_i), .reset_i(reset_i), .cfg_i(cfg),
        .lock_flag_clear_i(lock_clr), .crystal_flag_clear_i(xtal_clr),
        .crystal_input_pin_i(pin), .vco_clock_o(vco), .feedback_clock_o(fb),
        .loop_reference_clock_o(refc), .loop_output_clock_o(outc), .bus_clock_o(busc),
        .crystal_clock_o(xclk), .status_o(st), .lock_irq_o(lirq), .crystal_irq_o(xirq));

    crystal_model xtal (.mclk_i(mclk_i), .run_i(run), .spike_i(spike), .half_i(half),
        .pin_o(pin));

    // ------------------------------------------------------------
    // Clock, edge trackers, watchdog
    // ------------------------------------------------------------
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i)
    begin
        fb_q   <= fb;
        pin_q  <= pin;
        filt_q <= xclk;
    end

    initial
    begin
        repeat (90000) @(posedge mclk_i);
        miscompares++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    function automatic logic ev(input int w);
        case (w)
            0:       return refc;
            1:       return vco;
            2:       return outc;
            3:       return busc;
            4:       return fb ^ fb_q;
            5:       return pin & ~pin_q;
            6:       return 1'b1;
            default: return xclk & ~filt_q;
        endcase
    endfunction : ev

    // Counts base events between two successive e events
    task automatic gap(input int e, input int b, output int n, input bit cont = 1'b0);
        int t;
        n = 0;
        t = 0;
        if (!cont)
            do begin @(posedge mclk_i); t++; end while (ev(e) !== 1'b1 && t < 4000);
        do
        begin
            @(posedge mclk_i);
            t++;
            if (ev(b) === 1'b1)
                n++;
        end while (ev(e) !== 1'b1 && t < 4000);
        if (t >= 4000)
            n = -1;
    endtask : gap

    task automatic wait_bit(input int idx, input int limit);
        int t;
        t = 0;
        while (st[idx] !== 1'b1 && t < limit)
        begin
            @(posedge mclk_i);
            t++;
        end
    endtask : wait_bit

    task automatic clear_flags();
        @(posedge mclk_i);
        lock_clr <= 1'b1;
        xtal_clr <= 1'b1;
        @(posedge mclk_i);
        lock_clr <= 1'b0;
        xtal_clr <= 1'b0;
        @(posedge mclk_i);
    endtask : clear_flags

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        int n;
        chk("status after reset", 0, st);
        chk("irq lines after reset", 0, {lirq, xirq});
        gap(2, 1, n);
        chk("vco ticks per output unlocked", 4, n);
        gap(3, 2, n);
        chk("output ticks per bus tick", 2, n);
        gap(0, 6, n);
        chk("cycles per internal reference", IRC_CYCLES, n);
    endtask : t_reset

    task automatic t_lock();
        int n;
        logic [4:0] divs [3] = '{5'h00, 5'h02, 5'h07};
        @(posedge mclk_i);
        cfg.synth_multiplier <= 6'h04;
        cfg.lock_irq_enable  <= 1'b1;
        wait_bit(3, 4000);
        chk("lock reached", 1, st.lock);
        chk("lock change flag", 1, st.lock_change_flag);
        chk("lock irq", 1, lirq);
        clear_flags();
        chk("lock irq after clear", 0, lirq);
        gap(4, 1, n);
        chk("vco ticks per feedback half", 5, n);
        gap(0, 1, n);
        chk("vco per reference in tolerance", 1, n >= 8 && n <= 12);
        foreach (divs[i])
        begin
            cfg.output_divider <= divs[i];
            repeat (40) @(posedge mclk_i);
            gap(2, 1, n);
            chk("vco ticks per output locked", divs[i] + 1, n);
            gap(3, 2, n);
            chk("output ticks per bus tick", 2, n);
        end
    endtask : t_lock

    task automatic t_crystal();
        int n;
        @(posedge mclk_i);
        half                  <= 8'd10;
        run                   <= 1'b1;
        cfg.crystal_enable    <= 1'b1;
        cfg.reference_divider <= 4'h1;
        repeat (200) @(posedge mclk_i);
        gap(0, 5, n);
        chk("crystal edges per reference", 2, n);
        cfg.bus_source_select <= 1'b0;
        repeat (40) @(posedge mclk_i);
        gap(3, 5, n);
        chk("crystal edges per bus tick", 1, n);
        cfg.bus_source_select <= 1'b1;
    endtask : t_crystal

    task automatic t_filter(input logic [4:0] ratio, input logic wide, input logic [7:0] h,
                            input logic [3:0] rdiv, input logic det);
        int n;
        @(posedge mclk_i);
        run                    <= 1'b1;
        half                   <= h;
        cfg.reference_divider  <= rdiv;
        cfg.synth_multiplier   <= 6'h03;
        cfg.spike_filter_ratio <= ratio;
        cfg.filter_wide_window <= wide;
        cfg.crystal_irq_enable <= 1'b1;
        cfg.output_divider     <= 5'h00;
        wait_bit(3, 8000);
        chk("lock with crystal reference", 1, st.lock);
        if (ratio != 5'h00)
        begin
            wait_bit(2, 2000);
            chk("crystal qualified", 1, st.crystal_qualified);
        end
        if (ratio == 5'h04)
        begin
            spike <= 1'b1;
            @(posedge mclk_i);
            spike <= 1'b0;
            gap(7, 6, n);
            for (int i = 0; i < 4; i++)
            begin
                chk("filtered period", 1, n >= 2 * h - 4 && n <= 2 * h + 4);
                gap(7, 6, n, 1'b1);
            end
        end
        clear_flags();
        run <= 1'b0;
        repeat (8 * h) @(posedge mclk_i);
        chk("crystal flag after stall", det, st.crystal_change_flag);
        chk("crystal irq after stall", det, xirq);
        if (!det)
            chk("qualified held without detection", 1, st.crystal_qualified);
        if (det)
        begin
            chk("lock flag after stall", 1, st.lock_change_flag);
            chk("lock after stall", 0, st.lock);
            chk("qualified after noise", 0, st.crystal_qualified);
            gap(2, 1, n);
            chk("vco ticks per output on noise", 4, n);
        end
    endtask : t_filter

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        miscompares = 0;
        tests_run   = 0;
        reset_i     = 1'b1;
        lock_clr    = 1'b0;
        xtal_clr    = 1'b0;
        run         = 1'b0;
        spike       = 1'b0;
        half        = 8'd16;
        cfg         = '0;
        cfg.synth_multiplier  = RST_SYN;
        cfg.output_divider    = RST_POST;
        cfg.bus_source_select = 1'b1;
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        t_reset();
        t_lock();
        t_crystal();
        t_filter(5'h04, 1'b1, 8'd16, 4'h0, 1'b1);
        t_filter(5'h02, 1'b0, 8'd8, 4'h1, 1'b1);
        t_filter(5'h02, 1'b1, 8'd8, 4'h1, 1'b0);
        t_filter(5'h00, 1'b0, 8'd16, 4'h0, 1'b0);
        cfg.lock_irq_enable    <= 1'b0;
        cfg.crystal_irq_enable <= 1'b0;
        @(posedge mclk_i);
        finish_test();
    end
endmodule : tb_pll_clock_generator_osc_filter
